// [rtl/dbgc_pkg.sv]
// package: register map, field layout and carrier types of the comparator c extension block
package dbgc_pkg;
  // register indices; the byte address is four times the index
  localparam logic [5:0] IDX_COMP_C_EXT = 6'h0A;
  localparam logic [5:0] IDX_TRACE_INFO = 6'h0B;
  localparam logic [5:0] IDX_COMP_C_ADDR = 6'h10;
  localparam logic [5:0] IDX_DEBUG_CTRL = 6'h11;
  localparam logic [7:0] ADDR_COMP_C_EXT = {IDX_COMP_C_EXT, 2'h0};
  localparam logic [7:0] ADDR_TRACE_INFO = {IDX_TRACE_INFO, 2'h0};
  localparam logic [7:0] ADDR_COMP_C_ADDR = {IDX_COMP_C_ADDR, 2'h0};
  localparam logic [7:0] ADDR_DEBUG_CTRL = {IDX_DEBUG_CTRL, 2'h0};
  // comparator c extension fields
  localparam int EXT_RW_EN_BIT = 7;
  localparam int EXT_RW_VAL_BIT = 6;
  localparam int EXT_PAGED_BIT = 5;
  localparam int EXT_BIT16_BIT = 0;
  localparam logic [7:0] EXT_IMPL_MASK = 8'hE1;
  localparam logic [7:0] EXT_RESET = 8'h00;
  // trace word info fields
  localparam int INFO_PAGED_BIT = 7;
  localparam int INFO_BIT16_BIT = 0;
  localparam logic [7:0] INFO_RESET = 8'h00;
  // debug control fields
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_TRIG_BEFORE_BIT = 6;
  localparam logic [7:0] CTRL_IMPL_MASK = 8'hC0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COMP_ADDR_RESET = 16'h0000;
  // core address bus as seen by the comparator
  typedef struct packed {
    logic valid;
    logic rd;
    logic paged;
    logic [2:0] page;
    logic [16:0] addr;
  } dbgc_core_bus_t;
  // one captured trace word with its extension
  typedef struct packed {
    logic paged;
    logic [16:0] addr;
  } dbgc_capture_t;
  // extension of the fifo word currently presented for reading
  typedef struct packed {
    logic event_only;
    logic paged;
    logic bit16;
  } dbgc_fifo_word_t;
endpackage : dbgc_pkg

// [rtl/dbgc_comparator_ext.sv]
// comparator c extension, trace word extension info and their apb register window
//
// The implementer's own choice: the APB slave port.
module dbgc_comparator_ext (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sys_reset,
  input wire logic mcu_secure,
  input wire dbgc_pkg::dbgc_core_bus_t core_bus,
  input wire logic capture_req,
  input wire logic capture_event_only,
  input wire dbgc_pkg::dbgc_fifo_word_t fifo_word,
  output logic comp_c_match,
  output dbgc_pkg::dbgc_capture_t capture_word,
  output logic capture_valid,
  output logic debug_module_enable,
  output logic trigger_before_store
);
  import dbgc_pkg::*;

  typedef enum {DBGC_IDLE, DBGC_ACCESS} dbgc_apb_state_t;

  logic [7:0] comp_c_extension;
  logic [7:0] trace_word_extension_info;
  logic [15:0] comp_c_addr;
  logic [7:0] debug_ctrl;
  dbgc_apb_state_t apb_state;
  logic setup_phase;
  logic wr_take;
  logic keep_on_reset;
  logic [16:0] core_eff_addr;
  logic next_match;
  logic [31:0] next_rdata;
  logic next_err;

  // true when the byte address is an aligned, mapped register
  function automatic logic dbgc_mapped(input logic [7:0] a);
    dbgc_mapped = (a == ADDR_COMP_C_EXT) || (a == ADDR_TRACE_INFO) ||
                  (a == ADDR_COMP_C_ADDR) || (a == ADDR_DEBUG_CTRL);
  endfunction : dbgc_mapped

  // address the comparator sees: page index over the low fourteen bits when paged
  function automatic logic [16:0] dbgc_eff_addr(input dbgc_core_bus_t b);
    dbgc_eff_addr = b.paged ? {b.page, b.addr[13:0]} : b.addr;
  endfunction : dbgc_eff_addr

  assign setup_phase = psel && !penable;
  // single wait-free access: answer lands in the access phase
  assign pready = 1'b1;
  assign wr_take = psel && penable && pwrite && !pslverr;
  // end-trace reset: module enabled with trigger at end of stored data
  assign keep_on_reset = debug_ctrl[CTRL_ENABLE_BIT] && !debug_ctrl[CTRL_TRIG_BEFORE_BIT];
  assign debug_module_enable = debug_ctrl[CTRL_ENABLE_BIT];
  assign trigger_before_store = debug_ctrl[CTRL_TRIG_BEFORE_BIT];
  assign core_eff_addr = dbgc_eff_addr(core_bus);

  // apb phase tracker, kept for clearing the error flag when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= DBGC_IDLE;
    end else begin
      case (apb_state)
        DBGC_IDLE: begin
          if (setup_phase) begin
            apb_state <= DBGC_ACCESS;
          end
        end
        DBGC_ACCESS: begin
          apb_state <= setup_phase ? DBGC_ACCESS : DBGC_IDLE;
        end
        default: begin
          apb_state <= DBGC_IDLE;
        end
      endcase
    end
  end

  // read mux, sampled in the setup cycle so prdata comes from a flop
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err = !dbgc_mapped(paddr);
    case (paddr)
      ADDR_COMP_C_EXT: begin
        next_rdata = {24'h00_0000, comp_c_extension & EXT_IMPL_MASK};
      end
      ADDR_TRACE_INFO: begin
        next_rdata = {24'h00_0000, trace_word_extension_info};
      end
      ADDR_COMP_C_ADDR: begin
        next_rdata = {16'h0000, comp_c_addr};
      end
      ADDR_DEBUG_CTRL: begin
        next_rdata = {24'h00_0000, debug_ctrl & CTRL_IMPL_MASK};
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data and error flag, held through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end else if (apb_state == DBGC_IDLE) begin
      pslverr <= 1'b0;
    end
  end

  // comparator c extension register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_c_extension <= EXT_RESET;
    end else if (sys_reset) begin
      if (!keep_on_reset) begin
        comp_c_extension <= EXT_RESET;
      end
    end else if (wr_take && paddr == ADDR_COMP_C_EXT) begin
      comp_c_extension <= pwdata[7:0] & EXT_IMPL_MASK;
    end
  end

  // comparator c base address, low sixteen bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_c_addr <= COMP_ADDR_RESET;
    end else if (sys_reset) begin
      if (!keep_on_reset) begin
        comp_c_addr <= COMP_ADDR_RESET;
      end
    end else if (wr_take && paddr == ADDR_COMP_C_ADDR) begin
      comp_c_addr <= pwdata[15:0];
    end
  end

  // debug control; the enable can never be set while the part is secured
  // a clearing reset wins over the secure forcing so the trigger bit clears too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_ctrl <= CTRL_RESET;
    end else if (sys_reset && !keep_on_reset) begin
      debug_ctrl <= CTRL_RESET;
    end else if (mcu_secure) begin
      debug_ctrl[CTRL_ENABLE_BIT] <= 1'b0;
    end else if (sys_reset) begin
      debug_ctrl <= debug_ctrl;
    end else if (wr_take && paddr == ADDR_DEBUG_CTRL) begin
      debug_ctrl <= pwdata[7:0] & CTRL_IMPL_MASK;
    end
  end

  // match decision; all qualifiers must agree in the same bus cycle
  always_comb begin
    next_match = core_bus.valid && debug_ctrl[CTRL_ENABLE_BIT];
    // direction only counts when its qualifier is on
    if (comp_c_extension[EXT_RW_EN_BIT]) begin
      next_match = next_match && (core_bus.rd == comp_c_extension[EXT_RW_VAL_BIT]);
    end
    // paged qualifier must equal the paging unit's indication
    next_match = next_match && (core_bus.paged == comp_c_extension[EXT_PAGED_BIT]);
    next_match = next_match && (core_eff_addr[16] == comp_c_extension[EXT_BIT16_BIT]);
    next_match = next_match && (core_eff_addr[15:0] == comp_c_addr);
  end

  // registered match pulse; one cycle latency trades speed for a clean output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_c_match <= 1'b0;
    end else begin
      comp_c_match <= next_match;
    end
  end

  // captured word with extension, handed to the trace fifo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_word <= '0;
      capture_valid <= 1'b0;
    end else begin
      capture_valid <= capture_req;
      if (capture_req) begin
        capture_word.paged <= core_bus.paged && !capture_event_only;
        capture_word.addr <= capture_event_only ? 17'h0_0000 : core_eff_addr;
      end
    end
  end

  // extension info of the word now at the fifo read side; writes never reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_word_extension_info <= INFO_RESET;
    end else if (sys_reset && !keep_on_reset) begin
      trace_word_extension_info <= INFO_RESET;
    end else if (!sys_reset) begin
      trace_word_extension_info <= '0;
      trace_word_extension_info[INFO_PAGED_BIT] <= fifo_word.paged && !fifo_word.event_only;
      trace_word_extension_info[INFO_BIT16_BIT] <= fifo_word.bit16 && !fifo_word.event_only;
    end
  end
endmodule : dbgc_comparator_ext

// [tb/dbgc_core_model.sv]
// core bus and paging unit model feeding the comparator
module dbgc_core_model (
  input wire logic pclk,
  input wire logic go,
  input wire dbgc_pkg::dbgc_core_bus_t req,
  output dbgc_pkg::dbgc_core_bus_t core_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus inverts its lines so a stale address never looks held
  initial core_bus = '0;
  always @(posedge pclk) core_bus <= go ? req : {1'b0, ~core_bus[21:0]};
endmodule : dbgc_core_model

// [tb/dbgc_props.sv]
// concurrent checks on the comparator c extension ports
module dbgc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic sys_reset,
  input wire logic mcu_secure,
  input wire dbgc_pkg::dbgc_core_bus_t core_bus,
  input wire logic capture_req,
  input wire logic capture_event_only,
  input wire logic comp_c_match,
  input wire dbgc_pkg::dbgc_capture_t capture_word,
  input wire logic capture_valid,
  input wire logic debug_module_enable,
  input wire logic trigger_before_store
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // capture request answered one cycle later
  sequence s_cap; capture_req ##1 capture_valid; endsequence
  property p_cap; capture_req |-> s_cap; endproperty
  property p_ev; capture_req && capture_event_only |=> capture_word == 18'h0; endproperty
  property p_pg; capture_req && !capture_event_only && core_bus.paged |=>
    capture_word == {1'b1, $past(core_bus.page), $past(core_bus.addr[13:0])}; endproperty
  property p_up; capture_req && !capture_event_only && !core_bus.paged |=>
    capture_word == {1'b0, $past(core_bus.addr)}; endproperty
  property p_off; !debug_module_enable |=> !comp_c_match; endproperty
  property p_idle; !core_bus.valid |=> !comp_c_match; endproperty
  property p_sec; mcu_secure |=> !debug_module_enable; endproperty
  property p_clr; sys_reset && !(debug_module_enable && !trigger_before_store) |=>
    !debug_module_enable && !trigger_before_store; endproperty
  property p_keep; sys_reset && !mcu_secure && debug_module_enable && !trigger_before_store |=>
    debug_module_enable && !trigger_before_store; endproperty
  property p_rdy; psel && penable |-> pready; endproperty
  a_cap: assert property (p_cap) else $error("capture not flagged");
  a_ev: assert property (p_ev) else $error("event word not cleared");
  a_pg: assert property (p_pg) else $error("paged word layout wrong");
  a_up: assert property (p_up) else $error("unpaged word wrong");
  a_off: assert property (p_off) else $error("match while disabled");
  a_idle: assert property (p_idle) else $error("match without bus cycle");
  a_sec: assert property (p_sec) else $error("enable set while secured");
  a_clr: assert property (p_clr) else $error("reset did not clear");
  a_keep: assert property (p_keep) else $error("end trace lost control");
  a_rdy: assert property (p_rdy) else $error("access not answered");
endmodule : dbgc_props
bind dbgc_comparator_ext dbgc_props dbgc_props_i (.pclk, .presetn, .psel, .penable, .pready, .sys_reset,
  .mcu_secure, .core_bus, .capture_req, .capture_event_only, .comp_c_match, .capture_word, .capture_valid,
  .debug_module_enable, .trigger_before_store);

// [tb/testbench.sv]
// self-checking bench for the comparator c extension block
module testbench import dbgc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sys_reset = 0, mcu_secure = 0;
  logic capture_req = 0, capture_event_only = 0, go = 0, pready, pslverr, er, comp_c_match;
  logic capture_valid, debug_module_enable, trigger_before_store, ev, ex;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, ext, ca;
  logic [16:0] eff;
  dbgc_core_bus_t req = '0, core_bus, b;
  dbgc_fifo_word_t fifo_word = '0, f;
  dbgc_capture_t capture_word;
  int miscompares = 0, n_tests = 0, en;
  always #2.5 pclk = ~pclk;
  dbgc_comparator_ext dbgc_comparator_ext_i (.*);
  dbgc_core_model dbgc_core_model_i (.pclk, .go, .req, .core_bus);
  // apb master: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) miscompares++;
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
    // let one edge pass so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic srst();
    sys_reset <= 1;
    @(posedge pclk);
    sys_reset <= 0;
    @(posedge pclk);
  endtask : srst
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // watchdog: the whole run needs fewer than a thousand cycles
  initial begin
    #100us;
    miscompares++;
    final_report();
  end
  // main sequence
  initial begin
    void'($urandom(32'h222106CC));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ADDR_COMP_C_EXT, 0); chk("ext_rst", rd, 0);
    apb(0, ADDR_DEBUG_CTRL, 0); chk("ctrl_rst", rd, 0);
    apb(1, ADDR_COMP_C_EXT, 32'hFF); apb(0, ADDR_COMP_C_EXT, 0); chk("ext_mask", rd, 32'hE1);
    apb(1, ADDR_TRACE_INFO, 32'hFF); apb(0, ADDR_TRACE_INFO, 0); chk("info_ro", rd, 0);
    apb(0, 8'h30, 0); chk("unmapped", er, 1);
    mcu_secure <= 1;
    apb(1, ADDR_DEBUG_CTRL, 32'h80); apb(0, ADDR_DEBUG_CTRL, 0); chk("secure", rd[7], 0);
    mcu_secure <= 0;
    $display("register test done");
    repeat (60) begin
      ext = $urandom & 32'hE1; ca = $urandom & 32'hFFFF; en = ($urandom % 4) != 0;
      apb(1, ADDR_COMP_C_EXT, ext); apb(1, ADDR_COMP_C_ADDR, ca); apb(1, ADDR_DEBUG_CTRL, {en[0], 7'h0});
      b = 23'($urandom); b.valid = ($urandom % 8) != 0; ev = $urandom;
      if ($urandom % 4 != 0) begin
        b.paged = ext[5]; b.rd = $urandom % 4 ? ext[6] : b.rd;
        if (b.paged) {b.page, b.addr[13:0]} = {ext[0], ca[15:0]};
        else b.addr = {ext[0], ca[15:0]};
      end
      eff = b.paged ? {b.page, b.addr[13:0]} : b.addr;
      ex = en && b.valid && (!ext[7] || b.rd == ext[6]) && b.paged == ext[5] && eff == {ext[0], ca[15:0]};
      go <= 1; req <= b; capture_event_only <= ev;
      @(posedge pclk);
      go <= 0; capture_req <= 1;
      @(posedge pclk);
      capture_req <= 0;
      #1;
      chk("match", comp_c_match, ex);
      chk("cap", capture_word, {b.paged && !ev, ev ? 17'h0 : eff});
      f = 3'($urandom); fifo_word <= f;
      @(posedge pclk);
      apb(0, ADDR_TRACE_INFO, 0);
      chk("info", rd, {f.paged && !f.event_only, 6'h0, f.bit16 && !f.event_only});
    end
    $display("match test done");
    apb(1, ADDR_COMP_C_EXT, 32'hA1); apb(1, ADDR_DEBUG_CTRL, 32'h80); srst();
    apb(0, ADDR_COMP_C_EXT, 0); chk("keep", rd, 32'hA1);
    apb(1, ADDR_DEBUG_CTRL, 32'hC0); srst();
    apb(0, ADDR_COMP_C_EXT, 0); chk("clear", rd, 0);
    $display("reset test done");
    final_report();
  end
endmodule : testbench
